// ==== design/cpp_core.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "cpp_defs.svh"
module cpp_core
    import cpp_pkg::*;
(
    input wire logic CLK, // Oscillator clock.
    input wire logic RST, // Synchronous reset, high.
    input wire logic CE, // Clock enable; low freezes all state.
    output logic [`CPP_PC_W-1:0] PMEM_ADDR, // Program memory word address.
    input wire logic [`CPP_INSN_W-1:0] PMEM_DATA, // Program memory word.
    output logic [`CPP_FADDR_W-1:0] FILE_ADDR, // Register file address.
    input wire logic [`CPP_DATA_W-1:0] FILE_RDATA, // Register file read data.
    output logic FILE_RD, // Operand read strobe.
    output logic [`CPP_DATA_W-1:0] FILE_WDATA, // Register file write data.
    output logic FILE_WR, // Destination write strobe.
    output logic PHASE_ONE, // Phase one of the cycle.
    output logic PHASE_TWO, // Phase two.
    output logic PHASE_THREE, // Phase three.
    output logic PHASE_FOUR, // Phase four.
    output logic [`CPP_DATA_W-1:0] WORK, // Working accumulator.
    output logic [2:0] FLAGS // Zero, digit carry, carry.
);
    ////////////////////////////////////////////////////////////////////////////////
    // Phase generator and state.
    cpp_phase_t phase, next_phase;
    logic [`CPP_PC_W-1:0] pc, next_pc;
    logic [`CPP_INSN_W-1:0] fetch_word, next_fetch_word;
    logic [`CPP_INSN_W-1:0] instruction_latch, next_instruction_latch;
    logic [`CPP_DATA_W-1:0] work, next_work;
    logic [`CPP_DATA_W-1:0] operand, next_operand;
    logic [`CPP_DATA_W-1:0] wdata, next_wdata;
    logic [2:0] flags, next_flags;
    logic flush, next_flush;
    logic [`CPP_PC_W-1:0] target, next_target;
    logic jump, next_jump;

    // Instruction fields.
    logic [11:0] ir;
    logic dest_file;
    logic [4:0] faddr;
    logic [7:0] lit;
    cpp_aluop_t op;
    logic use_lit, wr_file, wr_work, upd_c, upd_dc, upd_z, is_goto, is_call_like;
    logic is_bit, bit_set, skip_test, skip_on_set, move_work;
    logic [7:0] alu_a, alu_b, alu_res, bit_mask, res;
    logic alu_c, alu_dc, alu_z;

    assign ir = instruction_latch;
    assign faddr = ir[4:0];
    assign lit = ir[7:0];
    assign dest_file = ir[5];
    assign bit_mask = 8'h01 << ir[7:5];

    // Decode of the 12-bit word; field operations, bit operations and literals.
    always_comb begin
        op = CPP_OP_NONE;
        use_lit = 1'b0;
        wr_file = 1'b0;
        wr_work = 1'b0;
        upd_c = 1'b0;
        upd_dc = 1'b0;
        upd_z = 1'b0;
        is_goto = 1'b0;
        is_call_like = 1'b0;
        is_bit = 1'b0;
        bit_set = 1'b0;
        skip_test = 1'b0;
        skip_on_set = 1'b0;
        move_work = 1'b0;
        unique case (ir[11:10])
            2'b00: begin
                wr_file = dest_file;
                wr_work = ~dest_file;
                unique case (ir[9:6])
                    4'h0: begin
                        op = ir[5] ? CPP_OP_MOVB : CPP_OP_NONE;
                        move_work = ir[5];
                        wr_work = 1'b0;
                        wr_file = ir[5] && (ir[4:0] != 5'h00);
                    end
                    4'h1: begin
                        op = CPP_OP_CLR;
                        upd_z = 1'b1;
                    end
                    4'h2: begin
                        op = CPP_OP_SUB;
                        upd_c = 1'b1;
                        upd_dc = 1'b1;
                        upd_z = 1'b1;
                    end
                    4'h3: begin
                        op = CPP_OP_DEC;
                        upd_z = 1'b1;
                    end
                    4'h4: begin
                        op = CPP_OP_OR;
                        upd_z = 1'b1;
                    end
                    4'h5: begin
                        op = CPP_OP_AND;
                        upd_z = 1'b1;
                    end
                    4'h6: begin
                        op = CPP_OP_XOR;
                        upd_z = 1'b1;
                    end
                    4'h7: begin
                        op = CPP_OP_ADD;
                        upd_c = 1'b1;
                        upd_dc = 1'b1;
                        upd_z = 1'b1;
                    end
                    4'h8: begin
                        op = CPP_OP_MOVB;
                        upd_z = 1'b1;
                    end
                    4'h9: begin
                        op = CPP_OP_COM;
                        upd_z = 1'b1;
                    end
                    4'ha: begin
                        op = CPP_OP_INC;
                        upd_z = 1'b1;
                    end
                    4'hb: begin
                        op = CPP_OP_DEC;
                        skip_test = 1'b1;
                    end
                    4'hc: begin
                        op = CPP_OP_RRF;
                        upd_c = 1'b1;
                    end
                    4'hd: begin
                        op = CPP_OP_RLF;
                        upd_c = 1'b1;
                    end
                    4'he: op = CPP_OP_SWAP;
                    4'hf: begin
                        op = CPP_OP_INC;
                        skip_test = 1'b1;
                    end
                endcase
            end
            2'b01: begin
                is_bit = 1'b1;
                bit_set = ir[8];
                wr_file = ~ir[9];
                skip_test = ir[9];
                skip_on_set = ir[8];
            end
            2'b10: begin
                is_goto = ir[9];
                is_call_like = ~ir[9];
                use_lit = 1'b1;
                op = CPP_OP_MOVB;
                wr_work = ~ir[9] && (ir[8] == 1'b0);
            end
            2'b11: begin
                use_lit = 1'b1;
                wr_work = 1'b1;
                unique case (ir[9:8])
                    2'b00: op = CPP_OP_MOVB;
                    2'b01: begin
                        op = CPP_OP_OR;
                        upd_z = 1'b1;
                    end
                    2'b10: begin
                        op = CPP_OP_AND;
                        upd_z = 1'b1;
                    end
                    2'b11: begin
                        op = CPP_OP_XOR;
                        upd_z = 1'b1;
                    end
                endcase
            end
        endcase
    end

    // Accumulator is one operand, file register or literal the other.
    assign alu_a = work;
    assign alu_b = use_lit ? lit : operand;

    cpp_alu u_alu (
        .op(op),
        .a(alu_a),
        .b(alu_b),
        .carry_in(flags[`CPP_FLAG_C]),
        .result(alu_res),
        .carry_out(alu_c),
        .digit_carry_flag(alu_dc),
        .zero(alu_z)
    );

    always_comb begin
        if (is_bit) begin
            res = bit_set ? (operand | bit_mask) : (operand & ~bit_mask);
        end else if (move_work) begin
            // A move to a file register carries the accumulator, not the old file byte.
            res = work;
        end else begin
            res = alu_res;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic for the phase sequence and the two-stage pipeline.
    always_comb begin
        next_phase = phase;
        next_pc = pc;
        next_fetch_word = fetch_word;
        next_instruction_latch = instruction_latch;
        next_work = work;
        next_operand = operand;
        next_wdata = wdata;
        next_flags = flags;
        next_flush = flush;
        next_target = target;
        next_jump = jump;
        unique case (phase)
            CPP_PH_ONE: begin
                next_phase = CPP_PH_TWO;
                // A discarded prefetch runs as a no-op while the target is fetched.
                next_instruction_latch = flush ? `CPP_NOP : fetch_word;
                next_flush = 1'b0;
                next_pc = jump ? target : pc + 12'h001;
                next_jump = 1'b0;
            end
            CPP_PH_TWO: begin
                next_phase = CPP_PH_THREE;
                next_operand = FILE_RDATA;
            end
            CPP_PH_THREE: begin
                next_phase = CPP_PH_FOUR;
                next_wdata = res;
                if (upd_c) next_flags[`CPP_FLAG_C] = alu_c;
                if (upd_dc) next_flags[`CPP_FLAG_DC] = alu_dc;
                if (upd_z) next_flags[`CPP_FLAG_Z] = alu_z;
                if (wr_work) next_work = alu_res;
                if (is_goto || is_call_like) begin
                    next_target = {3'h0, ir[8:0]};
                    next_jump = is_goto;
                end
                // Skips and writes to the low program counter byte flush the prefetch.
                if (skip_test) begin
                    next_jump = is_bit ? (operand[ir[7:5]] == skip_on_set) : (alu_res == 8'h00);
                    next_target = pc + 12'h001;
                end
                if (wr_file && faddr == `CPP_PCL_ADDR) begin
                    next_jump = 1'b1;
                    next_target = {pc[11:8], res};
                end
            end
            CPP_PH_FOUR: begin
                next_phase = CPP_PH_ONE;
                next_fetch_word = PMEM_DATA;
                next_flush = jump;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            phase <= CPP_PH_ONE;
            pc <= `CPP_PC_RESET;
            fetch_word <= `CPP_NOP;
            instruction_latch <= `CPP_NOP;
            work <= 8'h00;
            operand <= 8'h00;
            wdata <= 8'h00;
            flags <= 3'h0;
            flush <= 1'b1;
            target <= 12'h000;
            jump <= 1'b0;
        end else if (CE) begin
            phase <= next_phase;
            pc <= next_pc;
            fetch_word <= next_fetch_word;
            instruction_latch <= next_instruction_latch;
            work <= next_work;
            operand <= next_operand;
            wdata <= next_wdata;
            flags <= next_flags;
            flush <= next_flush;
            target <= next_target;
            jump <= next_jump;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs. Program memory wraps within the on-chip array.
    assign PMEM_ADDR = pc & 12'(`CPP_PMEM_DEPTH - 1);
    assign FILE_ADDR = faddr;
    assign FILE_RD = (phase == CPP_PH_TWO);
    assign FILE_WR = (phase == CPP_PH_FOUR) && wr_file;
    assign FILE_WDATA = wdata;
    assign PHASE_ONE = (phase == CPP_PH_ONE);
    assign PHASE_TWO = (phase == CPP_PH_TWO);
    assign PHASE_THREE = (phase == CPP_PH_THREE);
    assign PHASE_FOUR = (phase == CPP_PH_FOUR);
    assign WORK = work;
    assign FLAGS = flags;
endmodule // cpp_core
`default_nettype wire

// ==== design/cpp_defs.svh ====
// Contract
// - Divide the clock by four into four non-overlapping phases forming one cycle.
// - Program counter advances by one at phase one of every cycle.
// - Instruction word is read and captured at phase four of fetch.
// - Instruction latch presents the instruction at phase one; execute in two to four.
// - Fetch and execute overlap; one instruction completes per cycle.
// - Instructions that change the program counter take two cycles.
// - Operand read at phase two, result written at phase four.
// - Each instruction is one 12-bit word over a separate program bus.
// - Eight-bit arithmetic unit: add, subtract, shift, logic, two's complement.
// - Accumulator supplies one operand; file register or literal the other.
// - Accumulator is an 8-bit register with no data memory address.
// - Arithmetic unit updates carry, digit carry and zero flags.
// - In subtraction carry and digit carry act as borrow outputs.
// - Special registers, program counter included, are mapped into data memory. The code maps only writes to the low program counter byte; flags stay in FLAGS.
// - Program memory is on chip, 512 or 1K words of 12 bits. The code provides 512 words only (CPP_PMEM_DEPTH).
`ifndef CPP_DEFS_SVH
`define CPP_DEFS_SVH
`define CPP_PC_W 12
`define CPP_INSN_W 12
`define CPP_DATA_W 8
`define CPP_FADDR_W 5
`define CPP_PMEM_DEPTH 512
`define CPP_NOP 12'h000
`define CPP_PC_RESET 12'hfff
`define CPP_PCL_ADDR 5'h02
`define CPP_STATUS_ADDR 5'h03
`define CPP_FLAG_C 0
`define CPP_FLAG_DC 1
`define CPP_FLAG_Z 2
`endif

// ==== design/cpp_pkg.sv ====
package cpp_pkg;
    typedef enum logic [1:0] {
        CPP_PH_ONE,
        CPP_PH_TWO,
        CPP_PH_THREE,
        CPP_PH_FOUR
    } cpp_phase_t;
    typedef enum logic [3:0] {
        CPP_OP_NONE,
        CPP_OP_ADD,
        CPP_OP_SUB,
        CPP_OP_AND,
        CPP_OP_OR,
        CPP_OP_XOR,
        CPP_OP_COM,
        CPP_OP_INC,
        CPP_OP_DEC,
        CPP_OP_RLF,
        CPP_OP_RRF,
        CPP_OP_MOVB,
        CPP_OP_CLR,
        CPP_OP_SWAP
    } cpp_aluop_t;
endpackage

// ==== design/cpp_alu.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "cpp_defs.svh"
module cpp_alu
    import cpp_pkg::*;
(
    input wire cpp_aluop_t op, // Operation.
    input wire logic [7:0] a, // Accumulator operand.
    input wire logic [7:0] b, // File or literal operand.
    input wire logic carry_in, // Carry for rotates.
    output logic [7:0] result, // Result byte.
    output logic carry_out, // Carry or not-borrow.
    output logic digit_carry_flag, // Nibble carry or not-borrow.
    output logic zero // Result is zero.
);
    logic [8:0] sum;
    logic [4:0] nib;
    always_comb begin
        sum = 9'h000;
        nib = 5'h00;
        result = b;
        carry_out = carry_in;
        digit_carry_flag = 1'b0;
        unique case (op)
            CPP_OP_ADD: begin
                sum = {1'b0, b} + {1'b0, a};
                nib = {1'b0, b[3:0]} + {1'b0, a[3:0]};
                result = sum[7:0];
                carry_out = sum[8];
                digit_carry_flag = nib[4];
            end
            CPP_OP_SUB: begin
                // Two's complement add of the inverse; a set carry means no borrow.
                sum = {1'b0, b} + {1'b0, ~a} + 9'h001;
                nib = {1'b0, b[3:0]} + {1'b0, ~a[3:0]} + 5'h01;
                result = sum[7:0];
                carry_out = sum[8];
                digit_carry_flag = nib[4];
            end
            CPP_OP_AND: result = a & b;
            CPP_OP_OR: result = a | b;
            CPP_OP_XOR: result = a ^ b;
            CPP_OP_COM: result = ~b;
            CPP_OP_INC: result = b + 8'h01;
            CPP_OP_DEC: result = b - 8'h01;
            CPP_OP_RLF: begin
                result = {b[6:0], carry_in};
                carry_out = b[7];
            end
            CPP_OP_RRF: begin
                result = {carry_in, b[7:1]};
                carry_out = b[0];
            end
            CPP_OP_CLR: result = 8'h00;
            CPP_OP_SWAP: result = {b[3:0], b[7:4]};
            CPP_OP_MOVB: result = b;
            CPP_OP_NONE: result = b;
        endcase
        zero = (result == 8'h00);
    end
endmodule // cpp_alu
`default_nettype wire

// ==== tb/cpp_core_assertions.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "cpp_defs.svh"
module cpp_core_assertions (
    input wire logic CLK, // Clock.
    input wire logic RST, // Reset.
    input wire logic CE, // Enable.
    input wire logic [`CPP_PC_W-1:0] PMEM_ADDR, // Program address.
    input wire logic FILE_RD, // Read strobe.
    input wire logic FILE_WR, // Write strobe.
    input wire logic PHASE_ONE, // Phase one.
    input wire logic PHASE_TWO, // Phase two.
    input wire logic PHASE_THREE, // Phase three.
    input wire logic PHASE_FOUR, // Phase four.
    input wire logic [`CPP_DATA_W-1:0] WORK, // Accumulator.
    input wire logic [2:0] FLAGS // Flags.
);
    default clocking @(posedge CLK);
    endclocking
    default disable iff (RST);
    sequence s_lead;
        PHASE_ONE && CE ##1 PHASE_TWO && CE ##1 PHASE_THREE && CE;
    endsequence
    a_phase_onehot: assert property (
        $onehot({PHASE_ONE, PHASE_TWO, PHASE_THREE, PHASE_FOUR}))
        else $error("phases not one-hot");
    a_phase_seq: assert property (s_lead |=> PHASE_FOUR)
        else $error("phase four did not follow");
    a_phase_wrap: assert property (PHASE_FOUR && CE |=> PHASE_ONE)
        else $error("cycle did not wrap to phase one");
    a_stall_freeze: assert property (!CE |=> $stable({PHASE_ONE, PHASE_FOUR, WORK, FLAGS}))
        else $error("state moved while disabled");
    a_pc_hold: assert property ((PHASE_TWO || PHASE_THREE) && CE |=> $stable(PMEM_ADDR))
        else $error("pc moved outside phase one");
    a_pc_range: assert property (PMEM_ADDR < 12'h200)
        else $error("program address beyond memory");
    a_read_phase: assert property (FILE_RD == PHASE_TWO)
        else $error("operand read outside phase two");
    a_write_phase: assert property (FILE_WR |-> PHASE_FOUR)
        else $error("write outside phase four");
    a_work_hold: assert property (!(PHASE_THREE && CE) |=> $stable({WORK, FLAGS}))
        else $error("accumulator changed other than on entry to phase four");
endmodule // cpp_core_assertions
bind cpp_core cpp_core_assertions u_chk (.CLK(CLK), .RST(RST), .CE(CE), .PMEM_ADDR(PMEM_ADDR),
    .FILE_RD(FILE_RD), .FILE_WR(FILE_WR), .PHASE_ONE(PHASE_ONE), .PHASE_TWO(PHASE_TWO),
    .PHASE_THREE(PHASE_THREE), .PHASE_FOUR(PHASE_FOUR), .WORK(WORK), .FLAGS(FLAGS));
`default_nettype wire

// ==== tb/cpp_mem_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module cpp_mem_model (
    input wire logic clk, // Clock.
    input wire logic ce, // Clock enable.
    input wire logic [11:0] pmem_addr, // Word address.
    output logic [11:0] pmem_data, // Program word.
    input wire logic [4:0] file_addr, // File address.
    output logic [7:0] file_rdata, // File read data.
    input wire logic file_rd, // Read strobe.
    input wire logic [7:0] file_wdata, // Write data.
    input wire logic file_wr // Write strobe.
);
    logic [11:0] prog [0:511];
    logic [7:0] regs [0:31];
    logic [7:0] last = 8'h00;
    assign pmem_data = prog[pmem_addr[8:0]];
    // A released read bus shows the inverse of the last byte, so late sampling cannot pass by luck.
    assign file_rdata = file_rd ? regs[file_addr] : ~last;
    always @(posedge clk) begin
        if (file_rd) last <= regs[file_addr];
        if (ce && file_wr) regs[file_addr] <= file_wdata;
    end
endmodule // cpp_mem_model
`default_nettype wire

// ==== tb/tb_core_phase_clock_pipeline.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_core_phase_clock_pipeline;
    localparam logic [3:0] LIT [0:3] = '{4'hc, 4'he, 4'hd, 4'hf};
    localparam logic [5:0] FOP [4:10] = '{6'h07, 6'h02, 6'h06, 6'h09, 6'h0d, 6'h0c, 6'h00};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [11:0] pmem_addr, pmem_data;
    logic [4:0] file_addr;
    logic [7:0] file_rdata, file_wdata, work;
    logic file_rd, file_wr, p1, p2, p3, p4;
    logic [2:0] flags;
    logic [31:0] seed = 32'd39192;
    logic [7:0] w = 8'h00;
    logic [7:0] mregs [0:31];
    logic [2:0] mf = 3'h0;
    logic [10:0] expq [$];
    int failures = 0;
    int samples_checked = 0;
    int pc = 0;
    cpp_core u_dut (.CLK(clk), .RST(rst), .CE(ce), .PMEM_ADDR(pmem_addr), .PMEM_DATA(pmem_data),
        .FILE_ADDR(file_addr), .FILE_RDATA(file_rdata), .FILE_RD(file_rd),
        .FILE_WDATA(file_wdata), .FILE_WR(file_wr), .PHASE_ONE(p1), .PHASE_TWO(p2),
        .PHASE_THREE(p3), .PHASE_FOUR(p4), .WORK(work), .FLAGS(flags));
    cpp_mem_model u_mem (.clk(clk), .ce(ce), .pmem_addr(pmem_addr), .pmem_data(pmem_data),
        .file_addr(file_addr), .file_rdata(file_rdata), .file_rd(file_rd),
        .file_wdata(file_wdata), .file_wr(file_wr));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("comparisons %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Places one random instruction of the given kind and steps the reference model.
    task automatic put(input int kind);
        logic [7:0] k, fv, r;
        logic [4:0] f;
        logic d, c, half;
        seed = xs(seed);
        k = seed[7:0];
        f = {2'b01, seed[10:8]};
        d = seed[11] || kind == 10;
        fv = mregs[f];
        c = mf[0];
        half = mf[1];
        case (kind)
            0: r = k;
            1: r = w & k;
            2: r = w | k;
            3: r = w ^ k;
            4: r = w + fv;
            5: r = fv - w;
            6: r = w ^ fv;
            7: r = ~fv;
            8: r = {fv[6:0], mf[0]};
            9: r = {mf[0], fv[7:1]};
            default: r = w;
        endcase
        if (kind == 4) c = {1'b0, w} + fv > 9'h0ff;
        if (kind == 4) half = {1'b0, w[3:0]} + fv[3:0] > 5'h0f;
        if (kind == 5) c = fv >= w;
        if (kind == 5) half = fv[3:0] >= w[3:0];
        if (kind == 8) c = fv[7];
        if (kind == 9) c = fv[0];
        if (kind >= 1 && kind <= 7) mf[2] = r == 8'h00;
        mf[1:0] = {half, c};
        if (kind >= 4 && d) mregs[f] = r;
        else w = r;
        u_mem.prog[pc] = kind < 4 ? {LIT[kind], k} : {FOP[kind], d, f};
        pc++;
        expq.push_back({mf, w});
    endtask
    // The word after a jump would corrupt the accumulator if it were not discarded.
    task automatic jump(input logic [8:0] to);
        u_mem.prog[pc] = {3'h5, to};
        u_mem.prog[pc + 1] = {4'hc, 8'h5a};
        pc = to;
        repeat (2) expq.push_back({mf, w});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        seed = xs(seed);
        ce <= seed[1:0] != 2'b00;
    end
    always @(posedge clk) begin
        if (!rst && p1 && ce && expq.size() > 0) check({5'h00, flags, work}, expq.pop_front());
    end
    initial begin
        for (int i = 0; i < 32; i++) begin
            seed = xs(seed);
            u_mem.regs[i] = seed[7:0];
            mregs[i] = seed[7:0];
        end
        for (int i = 0; i < 512; i++) u_mem.prog[i] = 12'h000;
        repeat (2) expq.push_back(11'h000);
        for (int i = 0; i < 44; i++) begin
            if (i == 22) jump(9'h100);
            put(i % 11);
        end
        jump(pc[8:0]);
        repeat (6) expq.push_back({mf, w});
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int n = 0; n < 3000 && expq.size() > 0; n++) @(posedge clk);
        check(16'(expq.size()), 16'h0000);
        for (int i = 8; i < 16; i++) check({8'h00, u_mem.regs[i]}, {8'h00, mregs[i]});
        close_out();
    end
endmodule // tb_core_phase_clock_pipeline
`default_nettype wire
